// File: src/hcc_pkg.sv
`default_nettype none

package hcc_pkg;

  // Register map: cursor bank select in bit 3, register in bits 1:0.
  localparam logic [7:0] ADDR_PIPE0   = 8'h10;
  localparam int         BANK_BIT     = 3;
  localparam logic [1:0] REG_CTRL     = 2'h0;
  localparam logic [1:0] REG_VEXT     = 2'h1;
  localparam logic [1:0] REG_BASE_LO  = 2'h2;
  localparam logic [1:0] REG_BASE_HI  = 2'h3;
  localparam logic [7:0] RESET_VALUE  = 8'h00;

  // Control register fields.
  localparam int CTL_MODE_MSB = 2;
  localparam int CTL_VEXT     = 3;
  localparam int CTL_HSTR     = 4;
  localparam int CTL_VSTR     = 5;
  localparam int CTL_BLINK    = 6;
  localparam int CTL_ORIGIN   = 7;
  localparam int PIPE0_ALT    = 0;
  localparam int PAT_SEL_LSB  = 4;

  // Mode field codes.
  localparam logic [2:0] MODE_OFF     = 3'h0;
  localparam logic [2:0] MODE_32AX    = 3'h1;
  localparam logic [2:0] MODE_64AX    = 3'h2;
  localparam logic [2:0] MODE_64C4    = 3'h3;
  localparam logic [2:0] MODE_64C3T   = 3'h4;
  localparam logic [2:0] MODE_128C2   = 3'h5;
  localparam logic [2:0] MODE_128C1T  = 3'h6;

  localparam logic [7:0] SIZE_32      = 8'h20;
  localparam logic [7:0] SIZE_64      = 8'h40;
  localparam logic [7:0] SIZE_128     = 8'h80;
  localparam logic [11:0] XOR_PLANE_OFF = 12'h008;

  // Alternate palette bases: cursor 2 at entries 0-3, cursor 1 at 4-7.
  localparam logic [2:0] PAL_C1_BASE  = 3'h4;
  localparam logic [2:0] PAL_C2_BASE  = 3'h0;
  localparam logic [2:0] PAL_CRT_BDR  = 3'h6;
  localparam logic [2:0] PAL_FP_BDR   = 3'h7;

  typedef struct packed {
    logic [1:0] data;
    logic [6:0] line;
  } hcc_pix_t;

  typedef struct packed {
    logic        fetchEn;
    logic        hStretch;
    logic        vStretch;
    logic        blink;
    logic        originBorder;
    logic [7:0]  width;
    logic [7:0]  height;
    logic [23:0] fetchAddr;
    logic        show;
    logic [2:0]  colorIdx;
    logic        invert;
  } hcc_cur_t;

  typedef struct packed {
    logic       alt;
    logic [7:0] index;
  } hcc_pal_t;

endpackage

`default_nettype wire

// File: src/hcc_cursor_config.sv
// Operation
// - Three-bit mode field per cursor control
// - Six modes: sizes and pixel encodings
// - Stretch only on flat panel, own enables
// - Stretch reuses main image stretch settings
// - Per-cursor blink enable bit
// - Origin bit: active area or border corner
// - Base address is frame buffer offset
// - Each cursor owns a 4KB region
// - 32x32 mode: four bits pick pattern
// - 64x64 modes: top two bits pick pattern
// - 128x128 modes: top bit picks pattern
// - Bit 3 takes height from extension
// - Width still set by mode
// - Alternate palette entries hold cursor colors
// - Pipeline bit 0 routes palette accesses
// - Border uses entries six and seven
// - AND/XOR pixel has two plane bits
// - AND zero colors, AND one transparent, XOR one inverts
// - 32x32 lines stored in 16-byte pairs
`timescale 1ns/100ps
`default_nettype none

module hcc_cursor_config (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire logic [7:0]             regAddr,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regWrStb,
  input  wire logic                   regRdStb,
  output logic [7:0]                  regRdData,
  input  wire logic                   flatPanelPin,
  input  wire logic                   borderEnPin,
  input  wire logic [7:0]             palSubAddr,
  input  wire hcc_pkg::hcc_pix_t [1:0] pixIn,
  output hcc_pkg::hcc_cur_t [1:0]     curOut,
  output hcc_pkg::hcc_pal_t           palRoute
);

  ////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [7:0] modeSize(input logic [2:0] m);
    case (m)
      hcc_pkg::MODE_32AX: modeSize = hcc_pkg::SIZE_32;
      hcc_pkg::MODE_64AX,
      hcc_pkg::MODE_64C4,
      hcc_pkg::MODE_64C3T: modeSize = hcc_pkg::SIZE_64;
      hcc_pkg::MODE_128C2,
      hcc_pkg::MODE_128C1T: modeSize = hcc_pkg::SIZE_128;
      default: modeSize = 8'h00;
    endcase
  endfunction

  // Offset of the selected pattern inside the 4KB region.
  function automatic logic [11:0] patOffset(input logic [2:0] m,
                                            input logic [3:0] sel);
    case (m)
      hcc_pkg::MODE_32AX: patOffset = {sel, 8'h00};
      hcc_pkg::MODE_64AX,
      hcc_pkg::MODE_64C4,
      hcc_pkg::MODE_64C3T: patOffset = {sel[3:2], 10'h000};
      hcc_pkg::MODE_128C2,
      hcc_pkg::MODE_128C1T: patOffset = {sel[3], 11'h000};
      default: patOffset = 12'h000;
    endcase
  endfunction

  // Offset of a line's first word inside its pattern.
  function automatic logic [11:0] lineOffset(input logic [2:0] m,
                                             input logic [6:0] ln);
    if (m == hcc_pkg::MODE_32AX) begin
      lineOffset = {2'h0, ln[6:1], 4'h0} | {9'h000, ln[0], 2'h0};
    end else begin
      lineOffset = {1'h0, ln, 4'h0};
    end
  endfunction

  // Returns {show, color number, invert} for one pixel.
  function automatic logic [3:0] pixDecode(input logic [2:0] m,
                                           input logic [1:0] d);
    case (m)
      hcc_pkg::MODE_32AX,
      hcc_pkg::MODE_64AX: begin
        if (!d[1]) begin
          pixDecode = {1'b1, 1'b0, d[0], 1'b0};
        end else begin
          pixDecode = {1'b0, 2'h0, d[0]};
        end
      end
      hcc_pkg::MODE_64C4: pixDecode = {1'b1, d, 1'b0};
      hcc_pkg::MODE_64C3T: pixDecode = {d != 2'h0, d, 1'b0};
      hcc_pkg::MODE_128C2: pixDecode = {1'b1, 1'b0, d[0], 1'b0};
      hcc_pkg::MODE_128C1T: pixDecode = {d[0], 3'h0};
      default: pixDecode = 4'h0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic [1:0] fpSync_reg;
  logic [1:0] bdrSync_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fpSync_reg  <= 2'h0;
      bdrSync_reg <= 2'h0;
    end else begin
      fpSync_reg  <= {fpSync_reg[0], flatPanelPin};
      bdrSync_reg <= {bdrSync_reg[0], borderEnPin};
    end
  end

  logic flatPanel;
  logic borderEn;
  assign flatPanel = fpSync_reg[1];
  assign borderEn  = bdrSync_reg[1];

  ////////////////////////////////////////////////////////////////////
  // Register file.

  logic [7:0] ctrl_reg   [2];
  logic [7:0] vext_reg   [2];
  logic [7:0] baseLo_reg [2];
  logic [7:0] baseHi_reg [2];
  logic [7:0] pipe0_reg;
  logic [7:0] rdData_reg;

  logic       bankHit;
  logic       bank;
  assign bankHit = (regAddr[7:4] == 4'h0) && !regAddr[2];
  assign bank    = regAddr[hcc_pkg::BANK_BIT];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 2; i++) begin
        ctrl_reg[i]   <= hcc_pkg::RESET_VALUE;
        vext_reg[i]   <= hcc_pkg::RESET_VALUE;
        baseLo_reg[i] <= hcc_pkg::RESET_VALUE;
        baseHi_reg[i] <= hcc_pkg::RESET_VALUE;
      end
      pipe0_reg <= hcc_pkg::RESET_VALUE;
    end else if (regWrStb) begin
      if (regAddr == hcc_pkg::ADDR_PIPE0) begin
        pipe0_reg <= regWrData;
      end else if (bankHit) begin
        case (regAddr[1:0])
          hcc_pkg::REG_CTRL: ctrl_reg[bank] <= regWrData;
          hcc_pkg::REG_VEXT: vext_reg[bank] <= regWrData;
          hcc_pkg::REG_BASE_LO: baseLo_reg[bank] <= regWrData;
          default: baseHi_reg[bank] <= regWrData;
        endcase
      end
    end
  end

  // Read data stands for one cycle only; unmapped addresses read zero.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdData_reg <= 8'h00;
    end else if (!regRdStb) begin
      rdData_reg <= 8'h00;
    end else if (regAddr == hcc_pkg::ADDR_PIPE0) begin
      rdData_reg <= pipe0_reg;
    end else if (bankHit) begin
      case (regAddr[1:0])
        hcc_pkg::REG_CTRL: rdData_reg <= ctrl_reg[bank];
        hcc_pkg::REG_VEXT: rdData_reg <= vext_reg[bank];
        hcc_pkg::REG_BASE_LO: rdData_reg <= baseLo_reg[bank];
        default: rdData_reg <= baseHi_reg[bank];
      endcase
    end else begin
      rdData_reg <= 8'h00;
    end
  end

  assign regRdData = rdData_reg;

  ////////////////////////////////////////////////////////////////////
  // Per-cursor configuration and pixel path.

  hcc_pkg::hcc_cur_t [1:0] cur_reg;
  hcc_pkg::hcc_cur_t [1:0] cur_next;

  always_comb begin
    logic [2:0]  m;
    logic [3:0]  px;
    logic        on;
    m  = 3'h0;
    px = 4'h0;
    on = 1'b0;
    for (int i = 0; i < 2; i++) begin
      m  = ctrl_reg[i][hcc_pkg::CTL_MODE_MSB:0];
      on = (modeSize(m) != 8'h00);
      px = pixDecode(m, pixIn[i].data);
      cur_next[i].fetchEn = on;
      // Only the enables live here; the stretch engine applies the
      // main image's algorithm and parameters to the cursor too.
      cur_next[i].hStretch = on && flatPanel
                             && ctrl_reg[i][hcc_pkg::CTL_HSTR];
      cur_next[i].vStretch = on && flatPanel
                             && ctrl_reg[i][hcc_pkg::CTL_VSTR];
      cur_next[i].blink = on && ctrl_reg[i][hcc_pkg::CTL_BLINK];
      cur_next[i].originBorder = ctrl_reg[i][hcc_pkg::CTL_ORIGIN];
      cur_next[i].width = modeSize(m);
      cur_next[i].height = ctrl_reg[i][hcc_pkg::CTL_VEXT] && on
                           ? vext_reg[i] : modeSize(m);
      // A 4KB-aligned region keeps pattern and line offsets in the low
      // 12 bits, so they are merged without a carry.
      cur_next[i].fetchAddr = on ? {baseHi_reg[i], baseLo_reg[i][3:0],
                              patOffset(m, baseLo_reg[i][7:4])
                              + lineOffset(m, pixIn[i].line)}
                              : 24'h000000;
      cur_next[i].show = px[3];
      cur_next[i].invert = px[0];
      cur_next[i].colorIdx = (i == 0 ? hcc_pkg::PAL_C1_BASE
                              : hcc_pkg::PAL_C2_BASE) | {1'b0, px[2:1]};
      // Entries 6 and 7 carry border colors, so cursor 1 falls back to
      // colors 0 and 1 while the border is on.
      if (i == 0 && borderEn && px[2]) begin
        cur_next[i].colorIdx = hcc_pkg::PAL_C1_BASE | {2'h0, px[1]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign curOut = cur_reg;

  ////////////////////////////////////////////////////////////////////
  // Palette sub-address routing.

  hcc_pkg::hcc_pal_t pal_reg;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pal_reg <= '0;
    end else begin
      pal_reg.alt   <= pipe0_reg[hcc_pkg::PIPE0_ALT];
      pal_reg.index <= pipe0_reg[hcc_pkg::PIPE0_ALT]
                       ? {5'h00, palSubAddr[2:0]} : palSubAddr;
    end
  end

  assign palRoute = pal_reg;

  ////////////////////////////////////////////////////////////////////
  // Checks.

  chk_pipe_route: assert property (@(posedge core_clk) disable iff (!reset_n)
    $past(pipe0_reg[0]) |-> palRoute.alt && palRoute.index[7:3] == 5'h00)
    else $error("Palette access not routed to alternate entries.");

  chk_ctrl_readback: assert property (@(posedge core_clk) disable iff (!reset_n)
    regWrStb && regAddr == 8'h08 ##1 regRdStb && regAddr == 8'h08
    |=> regRdData == $past(regWrData, 2))
    else $error("Cursor 2 control did not read back.");

  for (genvar g = 0; g < 2; g++) begin : gChk
    chk_disabled_quiet: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $past(ctrl_reg[g][2:0]) == 3'h0 |-> !curOut[g].fetchEn
      && !curOut[g].show && !curOut[g].invert)
      else $error("Disabled cursor still active.");

    chk_stretch_panel: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      curOut[g].hStretch || curOut[g].vStretch |-> $past(flatPanel))
      else $error("Cursor stretch without flat panel.");

    chk_vext_height: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $past(ctrl_reg[g][3]) && $past(ctrl_reg[g][2:0]) != 3'h0
      && $past(ctrl_reg[g][2:0]) != 3'h7
      |-> curOut[g].height == $past(vext_reg[g]))
      else $error("Extended height not taken.");

    chk_width_mode: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $past(ctrl_reg[g][2:0]) == 3'h5 |-> curOut[g].width == 8'h80)
      else $error("Width not set by mode.");

    chk_pattern_32: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      $past(ctrl_reg[g][2:0]) == 3'h1 |-> curOut[g].fetchAddr[11:8]
      == $past(baseLo_reg[g][7:4]))
      else $error("Pattern select wrong in 32x32 mode.");

    chk_base_offset: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      curOut[g].fetchEn |-> curOut[g].fetchAddr[23:12]
      == {$past(baseHi_reg[g]), $past(baseLo_reg[g][3:0])})
      else $error("Fetch address outside base region.");

    chk_andxor_clear: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      ($past(ctrl_reg[g][2:0]) == 3'h1 || $past(ctrl_reg[g][2:0]) == 3'h2)
      && $past(pixIn[g].data[1]) |-> !curOut[g].show
      && curOut[g].invert == $past(pixIn[g].data[0]))
      else $error("AND/XOR transparency wrong.");
  end

endmodule // hcc_cursor_config

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic                    core_clk;
  logic                    reset_n;
  logic [7:0]              regAddr;
  logic [7:0]              regWrData;
  logic                    regWrStb;
  logic                    regRdStb;
  logic [7:0]              regRdData;
  logic                    flatPanelPin;
  logic                    borderEnPin;
  logic [7:0]              palSubAddr;
  hcc_pkg::hcc_pix_t [1:0] pixIn;
  hcc_pkg::hcc_cur_t [1:0] curOut;
  hcc_pkg::hcc_pal_t       palRoute;
  int                      miscompares;
  int                      checkCount;
  logic [7:0]              ctl [2];
  logic [7:0]              vx [2];
  logic [7:0]              blo [2];
  logic [7:0]              bhi [2];
  hcc_pkg::hcc_pix_t       px [2];
  logic                    fp;
  logic                    bd;
  logic                    alt;
  logic [7:0]              sub;

  hcc_cursor_config hcc_cursor_config_inst (
    .core_clk    (core_clk),
    .reset_n     (reset_n),
    .regAddr     (regAddr),
    .regWrData   (regWrData),
    .regWrStb    (regWrStb),
    .regRdStb    (regRdStb),
    .regRdData   (regRdData),
    .flatPanelPin(flatPanelPin),
    .borderEnPin (borderEnPin),
    .palSubAddr  (palSubAddr),
    .pixIn       (pixIn),
    .curOut      (curOut),
    .palRoute    (palRoute)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic fail(string msg);
    miscompares++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
    checkCount++;
    if (got !== exp) fail($sformatf("register got %h exp %h", got, exp));
  endtask

  function automatic logic [7:0] adr(int i, logic [1:0] r);
    return (8'(i) << hcc_pkg::BANK_BIT) | {6'h00, r};
  endfunction

  function automatic logic [7:0] msize(logic [2:0] md);
    return md == 3'h1 ? hcc_pkg::SIZE_32 : md <= 3'h4 ? hcc_pkg::SIZE_64 : hcc_pkg::SIZE_128;
  endfunction

  // Expected cursor state; fields that the mode leaves undefined are masked out.
  function automatic hcc_pkg::hcc_cur_t exp_cur(int i, output hcc_pkg::hcc_cur_t m);
    hcc_pkg::hcc_cur_t e;
    logic [2:0] md;
    logic [11:0] off;
    logic [1:0] d;
    logic [1:0] col;
    logic sh;
    e = '0;
    m = '1;
    md = ctl[i][2:0];
    d = px[i].data;
    m.originBorder = 1'h0;
    m.colorIdx = 3'h0;
    if (md == hcc_pkg::MODE_OFF || md == 3'h7) return e;
    m.originBorder = 1'h1;
    e.fetchEn = 1'h1;
    e.hStretch = ctl[i][4] & fp;
    e.vStretch = ctl[i][5] & fp;
    e.blink = ctl[i][6];
    e.originBorder = ctl[i][7];
    e.width = msize(md);
    e.height = ctl[i][3] ? vx[i] : msize(md);
    if (md == hcc_pkg::MODE_32AX)
      off = {blo[i][7:4], 8'h00} + 12'(px[i].line >> 1) * 12'h010 + 12'(px[i].line[0]) * 12'h004;
    else if (md <= 3'h4)
      off = {blo[i][7:6], 10'h000} + 12'(px[i].line) * 12'h010;
    else
      off = {blo[i][7], 11'h000} + 12'(px[i].line) * 12'h010;
    e.fetchAddr = {bhi[i], blo[i][3:0], 12'h000} + 24'(off);
    col = d;
    sh = 1'h1;
    case (md)
      3'h1, 3'h2: begin
        sh = ~d[1];
        col = {1'h0, d[0]};
        e.invert = d == 2'h3;
      end
      3'h4: sh = d != 2'h0;
      3'h5: col = {1'h0, d[0]};
      3'h6: begin
        sh = d[0];
        col = 2'h0;
      end
      default: ;
    endcase
    if (i == 0 && bd) col[1] = 1'h0;
    e.show = sh;
    e.colorIdx = (i == 1 ? hcc_pkg::PAL_C2_BASE : hcc_pkg::PAL_C1_BASE) + {1'h0, col};
    m.colorIdx = {3{sh}};
    return e;
  endfunction

  task automatic chk_cur(int i);
    hcc_pkg::hcc_cur_t e;
    hcc_pkg::hcc_cur_t m;
    e = exp_cur(i, m);
    checkCount++;
    if ((curOut[i] & m) !== (e & m)) fail($sformatf("cursor %0d got %h exp %h", i, curOut[i], e));
  endtask

  task automatic chk_pal;
    hcc_pkg::hcc_pal_t e;
    e.alt = alt;
    e.index = alt ? {5'h00, sub[2:0]} : sub;
    checkCount++;
    if (palRoute !== e) fail($sformatf("palette got %h exp %h", palRoute, e));
  endtask

  // Strobes are lowered one edge later, and the next task waits an edge before raising.
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'h1;
    @(posedge core_clk);
    regWrStb <= 1'h0;
  endtask

  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk);
    regAddr <= a;
    regRdStb <= 1'h1;
    @(posedge core_clk);
    regRdStb <= 1'h0;
    @(negedge core_clk);
    chk_reg(regRdData, exp);
    @(negedge core_clk);
    chk_reg(regRdData, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    fail("watchdog expired");
    give_verdict();
  end

  initial begin
    logic [2:0] md;
    logic [7:0] v;
    miscompares = 0;
    checkCount = 0;
    reset_n = 1'h0;
    {regAddr, regWrData, regWrStb, regRdStb, palSubAddr} = '0;
    {flatPanelPin, borderEnPin} = 2'h0;
    pixIn = '0;
    void'($urandom(32'hE7CB9833));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    for (int i = 0; i < 9; i++) rd_chk(i < 8 ? adr(i / 4, 2'(i)) : hcc_pkg::ADDR_PIPE0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(adr(i / 4, 2'(i)), v);
      rd_chk(adr(i / 4, 2'(i)), v);
    end
    wr(hcc_pkg::ADDR_PIPE0, 8'h01);
    rd_chk(hcc_pkg::ADDR_PIPE0, 8'h01);
    // An unmapped address must neither store nor return anything.
    wr(8'h05, 8'hA5);
    rd_chk(8'h05, 8'h00);
    // Write then read of cursor 2 control with no idle cycle in between.
    v = 8'($urandom);
    @(posedge core_clk);
    regAddr <= adr(1, hcc_pkg::REG_CTRL);
    regWrData <= v;
    regWrStb <= 1'h1;
    @(posedge core_clk);
    regWrStb <= 1'h0;
    regRdStb <= 1'h1;
    @(posedge core_clk);
    regRdStb <= 1'h0;
    @(negedge core_clk);
    chk_reg(regRdData, v);
    for (int n = 0; n < 48; n++) begin
      // A line beyond the new mode's height is not legal once the mode changes.
      pixIn <= '0;
      fp = 1'($urandom);
      bd = 1'($urandom);
      alt = 1'($urandom);
      sub = 8'($urandom);
      for (int i = 0; i < 2; i++) begin
        md = 3'(n + 3 * i);
        ctl[i] = {5'($urandom), md};
        vx[i] = 8'($urandom);
        bhi[i] = 8'($urandom);
        blo[i] = 8'($urandom);
        // Unused pattern-select bits are kept at zero, as software must.
        if (md >= 3'h2 && md <= 3'h4) blo[i] = blo[i] & 8'hCF;
        if (md >= 3'h5) blo[i] = blo[i] & 8'h8F;
        px[i].data = 2'($urandom);
        px[i].line = 7'($urandom % int'(msize(md)));
        wr(adr(i, hcc_pkg::REG_CTRL), ctl[i]);
        wr(adr(i, hcc_pkg::REG_VEXT), vx[i]);
        wr(adr(i, hcc_pkg::REG_BASE_LO), blo[i]);
        wr(adr(i, hcc_pkg::REG_BASE_HI), bhi[i]);
      end
      wr(hcc_pkg::ADDR_PIPE0, {7'h00, alt});
      pixIn <= {px[1], px[0]};
      flatPanelPin <= fp;
      borderEnPin <= bd;
      palSubAddr <= sub;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk);
      chk_cur(0);
      chk_cur(1);
      chk_pal();
    end
    // A second reset in mid-run must disable both cursors again.
    @(posedge core_clk);
    reset_n <= 1'h0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'h1;
    ctl[0] = 8'h00;
    ctl[1] = 8'h00;
    @(negedge core_clk);
    chk_cur(0);
    chk_cur(1);
    rd_chk(adr(1, hcc_pkg::REG_CTRL), 8'h00);
    give_verdict();
  end
endmodule // testbench

`default_nettype wire
